/* File: pesc_pkg.sv */
package pesc_pkg;
  localparam int          NCNT            = 2;
  localparam int          CW              = 16;
  localparam logic [11:0] ADDR_STATUS     = 12'h38e;
  localparam logic [11:0] ADDR_CTRL       = 12'h38f;
  localparam logic [11:0] ADDR_OVF_CLEAR  = 12'h390;
  localparam logic [11:0] ADDR_SAMPLE_EN  = 12'h3f1;
  localparam logic [11:0] ADDR_MISC       = 12'h1a0;
  localparam logic [11:0] ADDR_CNT0       = 12'h0c1;
  localparam logic [11:0] ADDR_CFG0       = 12'h360;
  localparam int          MISC_MON_BIT    = 7;
  localparam int          MISC_NOSAMP_BIT = 12;
  localparam int          CFG_ENABLE_BIT  = 12;
  localparam int          CFG_OVFINT_BIT  = 26;
  localparam int          CFG_OVF_BIT     = 31;
  localparam int          CFG_RELOAD_LSB  = 32;
  localparam int          SAMPLE_CNT      = 0;
  localparam int          QUIET_CYCLES    = 8;
  localparam logic [63:0] RESET_ZERO      = 64'h0;
endpackage

/* File: pesc_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module pesc_counter (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 run,
  input  wire logic                 event_in,
  input  wire logic                 load,
  input  wire logic [pesc_pkg::CW-1:0] load_val,
  output logic [pesc_pkg::CW-1:0]   count,
  output logic                      wrap
);
  typedef struct packed {
    logic [pesc_pkg::CW-1:0] cnt_r;
    logic                    wrap_r;
  } pesc_cnt_state_t;
  pesc_cnt_state_t s_r, s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wrap_r = 1'b0;
    if (load)
      s_nxt.cnt_r = load_val;
    else if (run && event_in)
    begin
      s_nxt.cnt_r = s_r.cnt_r + 1'b1;
      s_nxt.wrap_r = &s_r.cnt_r;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign count = s_r.cnt_r;
  assign wrap  = s_r.wrap_r;
endmodule
`default_nettype wire

/* File: pesc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module pesc_ctrl (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [63:0]          reg_wdata,
  output logic [63:0]               reg_rdata,
  output logic                      reg_ack,
  input  wire logic [1:0]           event_in,
  input  wire logic                 legacy_mode,
  input  wire logic                 freeze_on_interrupt,
  input  wire logic                 sample_pass,
  input  wire logic                 sample_fail,
  input  wire logic                 branch_trace_irq,
  output logic                      perf_monitor_interrupt,
  output logic                      sample_armed,
  output logic                      sample_store,
  output logic                      quiet_busy
);
  localparam int N  = pesc_pkg::NCNT;
  localparam int CW = pesc_pkg::CW;
  typedef struct packed {
    logic [N-1:0]    ctrl_r;
    logic [N-1:0]    status_r;
    logic            samp_en_r;
    logic [N-1:0]    cfg_en_r;
    logic [N-1:0]    cfg_ovf_r;
    logic [N-1:0]    cfg_int_r;
    logic [N*CW-1:0] reload_r;
    logic [63:0]     rdata_r;
    logic            ack_r;
    logic            irq_r;
    logic            armed_r;
    logic            store_r;
    logic [3:0]      quiet_r;
    logic [N-1:0]    ev_s1_r;
    logic [N-1:0]    ev_s2_r;
    logic            busy_r;
  } pesc_state_t;
  pesc_state_t s_r, s_nxt;
  logic [N-1:0]    run;
  logic [N-1:0]    load;
  logic [N-1:0]    wrap;
  logic [N*CW-1:0] count;
  logic            passed;
  assign passed = s_r.armed_r && sample_pass && !sample_fail;
  // Legacy style gates on its own enable, else global control
  assign run = legacy_mode ? s_r.cfg_en_r : s_r.ctrl_r;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_cnt
      // Counter writes honoured any time except on the sampling counter in a pass cycle, which loads its reload value; a write wins over a same-cycle event
      assign load[gi] = (reg_wr && reg_addr == pesc_pkg::ADDR_CNT0 + 12'(gi))
                        || (passed && gi == pesc_pkg::SAMPLE_CNT);
      pesc_counter u_cnt (
        .mclk     (mclk),
        .rst      (rst),
        .run      (run[gi]),
        .event_in (s_r.ev_s2_r[gi]),
        .load     (load[gi]),
        .load_val ((passed && gi == pesc_pkg::SAMPLE_CNT) ? s_r.reload_r[gi*CW +: CW]
                                                          : reg_wdata[CW-1:0]),
        .count    (count[gi*CW +: CW]),
        .wrap     (wrap[gi])
      );
    end
  endgenerate
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack_r   = reg_wr || reg_rd;
    s_nxt.store_r = passed;
    // Two flops against metastability on the event pins
    s_nxt.ev_s1_r = event_in;
    s_nxt.ev_s2_r = s_r.ev_s1_r;
    // Count down first so a fresh window below overrides it
    if (s_r.quiet_r != 4'h0)
      s_nxt.quiet_r = s_r.quiet_r - 4'h1;
    if (reg_wr)
    begin
      unique case (reg_addr)
        pesc_pkg::ADDR_CTRL:      s_nxt.ctrl_r = reg_wdata[N-1:0];
        pesc_pkg::ADDR_OVF_CLEAR: s_nxt.status_r = s_r.status_r & ~reg_wdata[N-1:0];
        pesc_pkg::ADDR_SAMPLE_EN:
        begin
          s_nxt.samp_en_r = reg_wdata[0];
          // Stopping sampling opens a quiet window for late records
          if (s_r.samp_en_r && !reg_wdata[0])
            s_nxt.quiet_r = 4'(pesc_pkg::QUIET_CYCLES);
        end
        default:
        begin
          for (int i = 0; i < N; i++)
            if (reg_addr == pesc_pkg::ADDR_CFG0 + 12'(i))
            begin
              s_nxt.cfg_en_r[i]  = reg_wdata[pesc_pkg::CFG_ENABLE_BIT];
              s_nxt.cfg_int_r[i] = reg_wdata[pesc_pkg::CFG_OVFINT_BIT];
              // Writing zero to the flag clears it
              if (!reg_wdata[pesc_pkg::CFG_OVF_BIT])
                s_nxt.cfg_ovf_r[i] = 1'b0;
              s_nxt.reload_r[i*CW +: CW] = reg_wdata[pesc_pkg::CFG_RELOAD_LSB +: CW];
            end
        end
      endcase
    end
    if (passed)
    begin
      s_nxt.status_r[pesc_pkg::SAMPLE_CNT] = 1'b0;
      s_nxt.armed_r = 1'b0;
    end
    if (sample_fail)
      s_nxt.armed_r = 1'b0;
    // Wrap beats a same-cycle clear
    for (int i = 0; i < N; i++)
      if (wrap[i])
      begin
        s_nxt.status_r[i]  = 1'b1;
        s_nxt.cfg_ovf_r[i] = 1'b1;
        // Only the designated counter arms sampling in either style
        if (i == pesc_pkg::SAMPLE_CNT && s_r.samp_en_r)
          s_nxt.armed_r = 1'b1;
      end
    // One shared interrupt for sampling, trace and overflow
    s_nxt.irq_r = passed || branch_trace_irq;
    // In global style only the sampling counter holds back its wrap interrupt, and only while sampling is enabled; legacy gates each on its own overflow-interrupt bit
    for (int i = 0; i < N; i++)
      if (wrap[i] && (legacy_mode ? s_r.cfg_int_r[i]
                                  : !(s_r.samp_en_r && i == pesc_pkg::SAMPLE_CNT)))
        s_nxt.irq_r = 1'b1;
    // Trace interrupts freeze the counters too
    if (s_nxt.irq_r && freeze_on_interrupt)
    begin
      s_nxt.ctrl_r   = '0;
      s_nxt.cfg_en_r = '0;
    end
    // Flopped so the busy pin comes straight from a register
    s_nxt.busy_r = s_nxt.quiet_r != 4'h0;
    s_nxt.rdata_r = 64'h0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        pesc_pkg::ADDR_STATUS:    s_nxt.rdata_r[N-1:0] = s_r.status_r;
        pesc_pkg::ADDR_CTRL:      s_nxt.rdata_r[N-1:0] = s_r.ctrl_r;
        pesc_pkg::ADDR_SAMPLE_EN: s_nxt.rdata_r[0] = s_r.samp_en_r;
        pesc_pkg::ADDR_MISC:
        begin
          s_nxt.rdata_r[pesc_pkg::MISC_MON_BIT]    = 1'b1;
          s_nxt.rdata_r[pesc_pkg::MISC_NOSAMP_BIT] = 1'b0;
        end
        default:
        begin
          for (int i = 0; i < N; i++)
          begin
            // Live value; may miss events right at the read
            if (reg_addr == pesc_pkg::ADDR_CNT0 + 12'(i))
              s_nxt.rdata_r[CW-1:0] = count[i*CW +: CW];
            if (reg_addr == pesc_pkg::ADDR_CFG0 + 12'(i))
            begin
              s_nxt.rdata_r[pesc_pkg::CFG_ENABLE_BIT] = s_r.cfg_en_r[i];
              s_nxt.rdata_r[pesc_pkg::CFG_OVFINT_BIT] = s_r.cfg_int_r[i];
              s_nxt.rdata_r[pesc_pkg::CFG_OVF_BIT]    = s_r.cfg_ovf_r[i];
              s_nxt.rdata_r[pesc_pkg::CFG_RELOAD_LSB +: CW] = s_r.reload_r[i*CW +: CW];
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign reg_rdata              = s_r.rdata_r;
  assign reg_ack                = s_r.ack_r;
  assign perf_monitor_interrupt = s_r.irq_r;
  assign sample_armed           = s_r.armed_r;
  assign sample_store           = s_r.store_r;
  assign quiet_busy             = s_r.busy_r;

  // Checks look at the registered state one edge after the cause
  clear_wins_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == pesc_pkg::ADDR_OVF_CLEAR && reg_wdata[0] && !wrap[0] && !passed)
    |=> !s_r.status_r[0])
    else $error("Overflow clear ignored");
  wrap_sets_a: assert property (@(posedge mclk) disable iff (rst)
    wrap[0] |=> s_r.status_r[0])
    else $error("Wrap lost");
  zero_ctrl_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == pesc_pkg::ADDR_CTRL && reg_wdata[N-1:0] == '0) |=> s_r.ctrl_r == '0)
    else $error("Counters still enabled");
  freeze_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.irq_r && $past(freeze_on_interrupt)) |-> s_r.ctrl_r == '0)
    else $error("No freeze on interrupt");
  sample_en_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == pesc_pkg::ADDR_SAMPLE_EN) |=> s_r.samp_en_r == $past(reg_wdata[0]))
    else $error("Sampling enable wrong");
  misc_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && reg_addr == pesc_pkg::ADDR_MISC)
    |=> reg_rdata[pesc_pkg::MISC_MON_BIT] && !reg_rdata[pesc_pkg::MISC_NOSAMP_BIT])
    else $error("Feature bits wrong");
  store_irq_a: assert property (@(posedge mclk) disable iff (rst)
    sample_store |-> perf_monitor_interrupt && !s_r.status_r[0] && !sample_armed)
    else $error("Sample store side effects missing");
  legacy_run_a: assert property (@(posedge mclk) disable iff (rst)
    (legacy_mode && s_r.cfg_en_r == '0 && load == '0) |=> $stable(count))
    else $error("Legacy counter moved while disabled");
  quiet_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == pesc_pkg::ADDR_SAMPLE_EN && s_r.samp_en_r && !reg_wdata[0])
    |=> quiet_busy [*7])
    else $error("Quiet window short");
  store_c: cover property (@(posedge mclk) disable iff (rst) sample_store);
  legacy_c: cover property (@(posedge mclk) disable iff (rst) legacy_mode && |wrap);
  fail_c:  cover property (@(posedge mclk) disable iff (rst) sample_armed && sample_fail);
  irq_c:   cover property (@(posedge mclk) disable iff (rst) perf_monitor_interrupt);
  quiet_c: cover property (@(posedge mclk) disable iff (rst) $fell(quiet_busy));
endmodule
`default_nettype wire

/* File: pesc_sw_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pesc_sw_model (
  input  wire logic        mclk,
  input  wire logic [63:0] reg_rdata,
  input  wire logic        reg_ack,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [11:0]      reg_addr,
  output logic [63:0]      reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 64'h0;
  end
  // One-cycle strobe; answer lands one edge later
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d,
                     output logic [63:0] q, output logic ok);
    @(negedge mclk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    // Answer stands only in the cycle after the strobe edge
    q = reg_rdata;
    ok = reg_ack;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Idle bus shows garbage so stale values never look valid
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic setup(input logic [63:0] pre);
    logic [63:0] q;
    logic        ok;
    acc(1'b1, pesc_pkg::ADDR_CTRL, 64'h0, q, ok);
    acc(1'b1, pesc_pkg::ADDR_OVF_CLEAR, 64'h3, q, ok);
    acc(1'b1, pesc_pkg::ADDR_CNT0, pre, q, ok);
    acc(1'b1, pesc_pkg::ADDR_CFG0, {16'h0, pre[15:0], 32'h0040_0000}, q, ok);
    acc(1'b1, pesc_pkg::ADDR_SAMPLE_EN, 64'h1, q, ok);
    acc(1'b1, pesc_pkg::ADDR_CTRL, 64'h1, q, ok);
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata;
  logic [63:0] reg_rdata;
  logic        reg_ack;
  logic [1:0]  event_in;
  logic        legacy_mode;
  logic        freeze_on_interrupt;
  logic        sample_pass;
  logic        sample_fail;
  logic        branch_trace_irq;
  logic        perf_monitor_interrupt;
  logic        sample_armed;
  logic        sample_store;
  logic        quiet_busy;
  logic [63:0] q;
  logic        ok;
  int          err_total;
  int          cmp_count;
  int          irq_n;
  int          store_n;
  int          n;
  int          s;
  pesc_sw_model sw (.mclk(mclk), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  pesc_ctrl dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .event_in(event_in), .legacy_mode(legacy_mode), .freeze_on_interrupt(freeze_on_interrupt),
    .sample_pass(sample_pass), .sample_fail(sample_fail), .branch_trace_irq(branch_trace_irq),
    .perf_monitor_interrupt(perf_monitor_interrupt), .sample_armed(sample_armed),
    .sample_store(sample_store), .quiet_busy(quiet_busy));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Pulses last one cycle, so count them as they pass
  always @(posedge mclk)
  begin
    if (perf_monitor_interrupt === 1'b1)
      irq_n <= irq_n + 1;
    if (sample_store === 1'b1)
      store_n <= store_n + 1;
  end
  task automatic end_of_test;
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [63:0] exp);
    sw.acc(1'b0, a, 64'h0, q, ok);
    chk({63'h0, ok}, 64'h1);
    chk(q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    sw.acc(1'b1, a, d, q, ok);
  endtask
  task automatic ev(input logic [1:0] m, input int k);
    event_in = m;
    repeat (k) @(negedge mclk);
    event_in = 2'b00;
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_reset;
    rdc(pesc_pkg::ADDR_STATUS, 64'h0);
    rdc(pesc_pkg::ADDR_CTRL, 64'h0);
    rdc(pesc_pkg::ADDR_SAMPLE_EN, 64'h0);
    sw.acc(1'b0, pesc_pkg::ADDR_MISC, 64'h0, q, ok);
    chk({62'h0, q[12], q[7]}, 64'h1);
    rdc(12'h7ff, 64'h0);
    wr(pesc_pkg::ADDR_OVF_CLEAR, 64'h3);
    rdc(pesc_pkg::ADDR_OVF_CLEAR, 64'h0);
  endtask
  task automatic t_count;
    wr(pesc_pkg::ADDR_CNT0, 64'h0);
    wr(pesc_pkg::ADDR_CNT0 + 12'h1, 64'h0);
    wr(pesc_pkg::ADDR_CTRL, 64'h1);
    ev(2'b11, 5);
    wr(pesc_pkg::ADDR_CTRL, 64'h0);
    rdc(pesc_pkg::ADDR_CNT0, 64'h5);
    rdc(pesc_pkg::ADDR_CNT0 + 12'h1, 64'h0);
    ev(2'b11, 3);
    rdc(pesc_pkg::ADDR_CNT0, 64'h5);
  endtask
  task automatic t_wrap;
    wr(pesc_pkg::ADDR_CNT0 + 12'h1, 64'hfffe);
    wr(pesc_pkg::ADDR_CTRL, 64'h2);
    n = irq_n;
    ev(2'b10, 2);
    chk(64'(irq_n - n), 64'h1);
    rdc(pesc_pkg::ADDR_STATUS, 64'h2);
    repeat (5) @(negedge mclk);
    rdc(pesc_pkg::ADDR_STATUS, 64'h2);
    wr(pesc_pkg::ADDR_OVF_CLEAR, 64'h1);
    rdc(pesc_pkg::ADDR_STATUS, 64'h2);
    wr(pesc_pkg::ADDR_OVF_CLEAR, 64'h2);
    rdc(pesc_pkg::ADDR_STATUS, 64'h0);
    wr(pesc_pkg::ADDR_CTRL, 64'h0);
    n = irq_n;
    branch_trace_irq = 1'b1;
    @(negedge mclk);
    branch_trace_irq = 1'b0;
    repeat (3) @(negedge mclk);
    chk(64'(irq_n - n), 64'h1);
  endtask
  task automatic t_sample;
    freeze_on_interrupt = 1'b1;
    wr(pesc_pkg::ADDR_CFG0, 64'h0000_ffff_0000_0000);
    sw.setup(64'hffff);
    rdc(pesc_pkg::ADDR_SAMPLE_EN, 64'h1);
    ev(2'b01, 1);
    repeat (8) if (sample_armed !== 1'b1) @(negedge mclk);
    chk({63'h0, sample_armed}, 64'h1);
    n = irq_n;
    s = store_n;
    sample_pass = 1'b1;
    @(negedge mclk);
    sample_pass = 1'b0;
    repeat (3) @(negedge mclk);
    chk(64'(store_n - s), 64'h1);
    chk(64'(irq_n - n), 64'h1);
    rdc(pesc_pkg::ADDR_STATUS, 64'h0);
    rdc(pesc_pkg::ADDR_CTRL, 64'h0);
    rdc(pesc_pkg::ADDR_CNT0, 64'hffff);
    wr(pesc_pkg::ADDR_CTRL, 64'h1);
    ev(2'b01, 1);
    repeat (8) if (sample_armed !== 1'b1) @(negedge mclk);
    s = store_n;
    sample_fail = 1'b1;
    @(negedge mclk);
    sample_fail = 1'b0;
    repeat (3) @(negedge mclk);
    chk(64'(store_n - s), 64'h0);
    wr(pesc_pkg::ADDR_SAMPLE_EN, 64'h0);
    chk({63'h0, quiet_busy}, 64'h1);
    repeat (12) if (quiet_busy !== 1'b0) @(negedge mclk);
    chk({63'h0, quiet_busy}, 64'h0);
  endtask
  task automatic t_legacy;
    legacy_mode = 1'b1;
    freeze_on_interrupt = 1'b0;
    wr(pesc_pkg::ADDR_CNT0 + 12'h1, 64'hffff);
    wr(pesc_pkg::ADDR_CFG0 + 12'h1, 64'h0);
    ev(2'b10, 2);
    rdc(pesc_pkg::ADDR_CNT0 + 12'h1, 64'hffff);
    wr(pesc_pkg::ADDR_CFG0 + 12'h1, 64'h0400_1000);
    n = irq_n;
    ev(2'b10, 1);
    chk(64'(irq_n - n), 64'h1);
    sw.acc(1'b0, pesc_pkg::ADDR_CFG0 + 12'h1, 64'h0, q, ok);
    chk({63'h0, q[31]}, 64'h1);
    wr(pesc_pkg::ADDR_CFG0 + 12'h1, 64'h0400_1000);
    sw.acc(1'b0, pesc_pkg::ADDR_CFG0 + 12'h1, 64'h0, q, ok);
    chk({63'h0, q[31]}, 64'h0);
  endtask
  initial
  begin
    #(3000 * 100);
    err_total++;
    end_of_test();
  end
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    irq_n = 0;
    store_n = 0;
    rst = 1'b1;
    event_in = 2'b00;
    legacy_mode = 1'b0;
    freeze_on_interrupt = 1'b0;
    sample_pass = 1'b0;
    sample_fail = 1'b0;
    branch_trace_irq = 1'b0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_count();
    t_wrap();
    t_sample();
    t_legacy();
    end_of_test();
  end
endmodule
`default_nettype wire
